// *** logic/lptsc_pkg.sv ***
// package for the loop switch and amplifier filter control registers
package lptsc_pkg;
	localparam logic [15:0] LPTSC_ADDR_LOOP_SWITCH = 16'h20E4;
	localparam logic [15:0] LPTSC_ADDR_AMP_FILTER  = 16'h20EC;
	localparam logic [31:0] LPTSC_RST_LOOP_SWITCH  = 32'h00000000;
	localparam logic [31:0] LPTSC_RST_AMP_FILTER   = 32'h00000003;
	// writable bits: switch 15 and 13..0; control 15..0 (bit 14 of switch is reserved)
	localparam logic [31:0] LPTSC_MASK_LOOP_SWITCH = 32'h0000BFFF;
	localparam logic [31:0] LPTSC_MASK_AMP_FILTER  = 32'h0000FFFF;
	localparam int          LPTSC_CAL_BIT          = 15;
	localparam int          LPTSC_NUM_LOOP_SW      = 14;
	localparam int          LPTSC_RF_LSB           = 13;
	localparam int          LPTSC_RF_MSB           = 15;
	localparam int          LPTSC_ADDR_W           = 16;
	localparam logic [1:0]  LPTSC_RESP_OKAY        = 2'h0;
	localparam logic [1:0]  LPTSC_RESP_SLVERR      = 2'h2;

	// filter resistor selection, binary-coded 3-bit value per setting
	typedef enum logic [2:0]
	{
		LPTSC_RF_OPEN  = 3'h0,
		LPTSC_RF_0R    = 3'h1,
		LPTSC_RF_20K   = 3'h2,
		LPTSC_RF_100K  = 3'h3,
		LPTSC_RF_200K  = 3'h4,
		LPTSC_RF_400K  = 3'h5,
		LPTSC_RF_600K  = 3'h6,
		LPTSC_RF_1M    = 3'h7
	} lptsc_rf_t;

	// analog control outputs bundled together
	typedef struct packed
	{
		logic        calibration_switch;
		logic [13:0] loop_switch;
		logic        filter_pin_connect;
		logic        filter_cap_connect;
		logic [6:0]  filter_resistor_onehot;
		logic [12:0] amp_ctrl_other;
	} lptsc_analog_t;
endpackage

// *** logic/lptsc_regs.sv ***
// AXI4-Lite register bank steering the low power amplifier loop switches and filter
// Functional notes
// - switch register at 0x20E4 resets to zero, all loop switches open.
// - control register at 0x20EC resets to 0x00000003.
// - switch register bit 15 closes the calibration switch when set.
// - switch register bits 13..0 each close the same-numbered loop switch.
// - control bits 15..13 are the filter resistor select field, reset zero.
// - select value 0 disconnects output from filter pin and capacitor.
// - select 1 bypasses with zero ohms, 2 gives 20k, 3 gives 100k.
// - select 4..7 give 200k, 400k, 600k and 1M.
`timescale 1ns/1ns
module lptsc_regs
	import lptsc_pkg::*;
(
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                clk_en,
	input  wire logic [15:0]         s_axi_awaddr,
	input  wire logic [2:0]          s_axi_awprot,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [15:0]         s_axi_araddr,
	input  wire logic [2:0]          s_axi_arprot,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output lptsc_analog_t            analog_ctrl
);

	logic [31:0]  loop_switch_config;
	logic [31:0]  amp_filter_control;
	logic         aw_held;
	logic         w_held;
	logic [15:0]  aw_addr;
	logic [31:0]  w_data;
	logic [3:0]   w_strb;
	logic         do_write;
	logic         next_ctrl_sel;
	lptsc_analog_t next_analog;

	// byte-lane merge of write data, keeping reserved bits zero
	function automatic logic [31:0] lptsc_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		end
		return res & mask;
	endfunction

	// address decode: returns 1 when the word address is mapped
	function automatic logic lptsc_hit(input logic [15:0] addr);
		return (addr[15:2] == LPTSC_ADDR_LOOP_SWITCH[15:2]) || (addr[15:2] == LPTSC_ADDR_AMP_FILTER[15:2]);
	endfunction

	// write address and data are captured independently, either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 16'h0000;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else if (clk_en)
		begin
			// ready is offered one cycle ahead, dropped once the item is held
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
			end
		end
	end

	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// register storage; writes to unmapped words are answered with an error
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			loop_switch_config <= LPTSC_RST_LOOP_SWITCH;
			amp_filter_control <= LPTSC_RST_AMP_FILTER;
		end
		else if (clk_en && do_write)
		begin
			if (aw_addr[15:2] == LPTSC_ADDR_LOOP_SWITCH[15:2])
				loop_switch_config <= lptsc_merge(loop_switch_config, w_data, w_strb, LPTSC_MASK_LOOP_SWITCH);
			if (aw_addr[15:2] == LPTSC_ADDR_AMP_FILTER[15:2])
				amp_filter_control <= lptsc_merge(amp_filter_control, w_data, w_strb, LPTSC_MASK_AMP_FILTER);
		end
	end

	// write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= LPTSC_RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= lptsc_hit(aw_addr) ? LPTSC_RESP_OKAY : LPTSC_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	assign next_ctrl_sel = (s_axi_araddr[15:2] == LPTSC_ADDR_AMP_FILTER[15:2]);

	// read channel: address taken only while no data is pending
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= LPTSC_RESP_OKAY;
		end
		else if (clk_en)
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				if (!lptsc_hit(s_axi_araddr))
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= LPTSC_RESP_SLVERR;
				end
				else
				begin
					// stored words already hold zeros in reserved bits
					s_axi_rdata <= next_ctrl_sel ? amp_filter_control : loop_switch_config;
					s_axi_rresp <= LPTSC_RESP_OKAY;
				end
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// decode of the stored fields into the analog controls
	always_comb
	begin
		next_analog = '0;
		next_analog.calibration_switch = loop_switch_config[LPTSC_CAL_BIT];
		next_analog.loop_switch        = loop_switch_config[LPTSC_NUM_LOOP_SW-1:0];
		next_analog.amp_ctrl_other     = amp_filter_control[LPTSC_RF_LSB-1:0];
		case (lptsc_rf_t'(amp_filter_control[LPTSC_RF_MSB:LPTSC_RF_LSB]))
			LPTSC_RF_OPEN:
			begin
				// output isolated from both the pin and the capacitor for fast settling
				next_analog.filter_pin_connect = 1'b0;
				next_analog.filter_cap_connect = 1'b0;
			end
			LPTSC_RF_0R:   next_analog.filter_resistor_onehot = 7'h01;
			LPTSC_RF_20K:  next_analog.filter_resistor_onehot = 7'h02;
			LPTSC_RF_100K: next_analog.filter_resistor_onehot = 7'h04;
			LPTSC_RF_200K: next_analog.filter_resistor_onehot = 7'h08;
			LPTSC_RF_400K: next_analog.filter_resistor_onehot = 7'h10;
			LPTSC_RF_600K: next_analog.filter_resistor_onehot = 7'h20;
			LPTSC_RF_1M:   next_analog.filter_resistor_onehot = 7'h40;
			default:       next_analog.filter_resistor_onehot = 7'h00;
		endcase
		if (amp_filter_control[LPTSC_RF_MSB:LPTSC_RF_LSB] != 3'h0)
		begin
			next_analog.filter_pin_connect = 1'b1;
			next_analog.filter_cap_connect = 1'b1;
		end
	end

	// registered analog outputs, one cycle behind the register contents
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			analog_ctrl <= '0;
		else if (clk_en)
			analog_ctrl <= next_analog;
	end

endmodule

// *** sim/lptsc_regs_chk.sv ***
// checker for the switch and filter register bank
`timescale 1ns/1ns
module lptsc_regs_chk
	import lptsc_pkg::*;
(
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic          clk_en,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic          s_axi_rvalid,
	input wire logic [31:0]   s_axi_rdata,
	input wire lptsc_analog_t analog_ctrl
);
	// one clock; reset masks all but the reset check
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire [6:0] oh = analog_ctrl.filter_resistor_onehot;
	// a low enable freezes every handshake, so only enabled edges make a take
	a_read_answer: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
	a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken busy");
	a_resp_drop: assert property (clk_en && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("resp held");
	a_resv_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("resv set");
	a_cap_link: assert property (analog_ctrl.filter_cap_connect == (|oh)) else $error("cap link");
	a_pin_link: assert property (analog_ctrl.filter_pin_connect == (|oh)) else $error("pin link");
	a_sel_onehot: assert property ($onehot0(oh)) else $error("select not one-hot");
	a_switch_reset: assert property (disable iff (1'b0) !aresetn |=> analog_ctrl.loop_switch == 14'h0000)
		else $error("switch closed in reset");
	cover property (s_axi_rvalid && s_axi_rdata[15]);
	cover property (oh == 7'h40);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind lptsc_regs lptsc_regs_chk lptsc_regs_chk_i (.*);

// *** sim/testbench.sv ***
// self-checking bench for the switch and filter register bank
`timescale 1ns/1ns
module testbench
	import lptsc_pkg::*;
;
	logic          aclk = 1'b0;
	logic          aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [15:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]   s_axi_wdata, s_axi_rdata;
	logic [3:0]    s_axi_wstrb;
	logic [1:0]    s_axi_bresp, s_axi_rresp, r;
	logic [33:0]   rv;
	lptsc_analog_t analog_ctrl;
	logic          clk_en;
	int            err_total, compares;
	// prot tied, enable driven by the sequence: the bank ignores prot, enable low only freezes
	lptsc_regs lptsc_regs_i (.clk_en(clk_en), .s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .*);
	initial
		forever #50 aclk = ~aclk;
	function automatic lptsc_analog_t ana(input logic [15:0] sw, input logic [15:0] ct);
		return {sw[15], sw[13:0], {2{ct[15:13] != 3'h0}}, (ct[15:13] == 3'h0) ? 7'h00 : 7'h01 << (ct[15:13] - 3'h1), ct[12:0]};
	endfunction
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		err_total += int'(seen !== exp);
		if (seen !== exp) $display("Error %s expected %h seen %h", nm, exp, seen);
	endtask
	// write when strobes are set, then read back; handshakes seen mid-cycle, acted on at the edge
	task automatic acc(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_t, w_t, b_t, ar_t, r_t;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, d, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{s != 4'h0}};
		{s_axi_arvalid, s_axi_rready} <= {2{s == 4'h0}};
		{r, r_t} = 3'h0;
		while (!r_t)
		begin
			@(negedge aclk);
			{aw_t, w_t, b_t} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid & s_axi_bready};
			{ar_t, r_t, rv} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid & s_axi_rready, s_axi_rresp, s_axi_rdata};
			if (b_t) r = s_axi_bresp;
			@(posedge aclk);
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {s_axi_awvalid & !aw_t, s_axi_wvalid & !w_t, s_axi_bready & !b_t};
			{s_axi_arvalid, s_axi_rready} <= {(s_axi_arvalid & !ar_t) | b_t, (s_axi_rready & !r_t) | b_t};
		end
	endtask
	task automatic wrap_up;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// main sequence
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 68'h0;
		clk_en = 1'b1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		acc(16'h20E4, 32'h0, 4'h0);
		chk("sw rst", {r, rv}, 36'h0);
		acc(16'h20EC, 32'h0, 4'h0);
		chk("con rst", {r, rv}, 36'h3);
		chk("ana rst", analog_ctrl, ana(16'h0, 16'h3));
		acc(16'h20E4, 32'hFFFFFFFF, 4'hF);
		chk("sw all", {r, rv}, 36'hBFFF);
		chk("ana all", analog_ctrl, ana(16'hBFFF, 16'h3));
		acc(16'h20E4, 32'h3FA5, 4'h1);
		chk("sw lane", {r, rv}, 36'hBFA5);
		chk("ana lane", analog_ctrl, ana(16'hBFA5, 16'h3));
		for (int i = 0; i < 8; i++)
		begin
			acc(16'h20EC, {16'hFFFF, i[2:0], 13'h0AAA}, 4'hF);
			chk("con", {r, rv}, {20'h0, i[2:0], 13'h0AAA});
			chk("ana sel", analog_ctrl, ana(16'hBFA5, {i[2:0], 13'h0AAA}));
		end
		acc(16'h20E8, 32'hFFFFFFFF, 4'hF);
		chk("unmapped", {r, rv}, {4'hA, 32'h0});
		// mid-run reset with the enable low: reset still acts, then state stays frozen
		@(posedge aclk);
		{aresetn, clk_en} <= 2'b00;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk("frozen ready", s_axi_arready, 1'b0);
		@(posedge aclk);
		clk_en <= 1'b1;
		acc(16'h20E4, 32'h0, 4'h0);
		chk("sw rst2", {r, rv}, 36'h0);
		acc(16'h20EC, 32'h0, 4'h0);
		chk("con rst2", {r, rv}, 36'h3);
		chk("ana rst2", analog_ctrl, ana(16'h0, 16'h3));
		wrap_up;
	end
	// about 15 accesses of at most 6 cycles each; a hang ends far past that
	initial
	begin
		repeat (2000) @(posedge aclk);
		err_total++;
		wrap_up;
	end
endmodule
